// [hdl/rio_module_end.sv]
`timescale 1ns/1ns
module rio_module_end
  import rio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link to com unit
  rio_if.module_end link,
  // Parameter bytes per input channel
  input wire logic [7:0] prm_ch1,
  input wire logic [7:0] prm_ch2,
  // Field inputs and line-fault sense
  input wire logic [1:0] field_in,
  input wire logic [1:0] line_fault_in,
  // Output side configuration
  input wire logic [7:0] out_replace,
  input wire logic [7:0] out_inv_mask,
  input wire logic [1:0] out_sub_mode,
  input wire logic watchdog_en,
  input wire logic bus_fault,
  // Field outputs
  output logic [7:0] field_out
);
  import rio_pkg::*;

  logic [1:0] s1_r, s2_r, s3_r;
  logic [1:0] f1_r, f2_r, f3_r;
  logic [1:0] filt_r;
  logic [1:0] lf_r;
  logic [31:0] dcnt_r [2];
  logic [31:0] tel_cnt_r;
  logic [31:0] loss_cnt_r;
  logic [7:0] tel_nxt;
  logic [7:0] last_valid_r;
  logic [7:0] held_r;
  logic [7:0] out_r;
  logic [7:0] prm [2];
  logic tel_push;
  logic link_lost;

  assign prm[0] = prm_ch1;
  assign prm[1] = prm_ch2;

  function automatic logic [31:0] delay_cycles(input logic [1:0] code);
    case (code)
      2'h1: delay_cycles = 32'(DELAY1_CYC);
      2'h2: delay_cycles = 32'(DELAY2_CYC);
      2'h3: delay_cycles = 32'(DELAY3_CYC);
      default: delay_cycles = 32'h0;
    endcase
  endfunction : delay_cycles

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, change accepted when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      f1_r <= '0;
      f2_r <= '0;
      f3_r <= '0;
    end else begin
      s1_r <= field_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f1_r <= line_fault_in;
      f2_r <= f1_r;
      f3_r <= f2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel on/off delay filter and line-fault gating
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic raw;
    logic [1:0] code;
    assign raw = (s2_r[c] == s3_r[c]) ? (s3_r[c] ^ prm[c][PB_INV]) : filt_r[c];
    assign code = raw ? prm[c][PB_ON+:2] : prm[c][PB_OFF+:2];

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        filt_r[c] <= 1'b0;
        dcnt_r[c] <= '0;
      end else if (raw == filt_r[c]) begin
        dcnt_r[c] <= '0;
      end else if (dcnt_r[c] + 32'h1 >= delay_cycles(code)) begin
        filt_r[c] <= raw;
        dcnt_r[c] <= '0;
      end else begin
        dcnt_r[c] <= dcnt_r[c] + 32'h1;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        lf_r[c] <= 1'b0;
      end else if (f2_r[c] == f3_r[c]) begin
        lf_r[c] <= f3_r[c] & prm[c][PB_LFD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cyclic input telegram
  always_comb begin
    tel_nxt = 8'h00;
    tel_nxt[TB_ST1] = filt_r[0];
    // Faulty channel delivers its live state; the fault bit marks it not valid
    tel_nxt[TB_LF1] = lf_r[0];
    tel_nxt[TB_ST2] = filt_r[1];
    tel_nxt[TB_LF2] = lf_r[1];
  end

  assign tel_push = tel_cnt_r == 32'(TELEGRAM_CYC - 1);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tel_cnt_r <= '0;
    end else if (tel_push) begin
      tel_cnt_r <= '0;
    end else begin
      tel_cnt_r <= tel_cnt_r + 32'h1;
    end
  end

  rio_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(tel_nxt),
    .in_valid(tel_push),
    .in_ready(),
    .out_data(link.tel_data),
    .out_valid(link.tel_valid),
    .out_ready(link.tel_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output path: strategy, freeze, inversion, link-loss shutdown
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loss_cnt_r <= '0;
    end else if (link.out_strobe) begin
      loss_cnt_r <= '0;
    end else if (!link_lost) begin
      loss_cnt_r <= loss_cnt_r + 32'h1;
    end
  end

  assign link_lost = loss_cnt_r >= 32'(LINK_LOSS_CYC);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      last_valid_r <= '0;
    end else if (link.out_strobe && !link.out_invalid) begin
      last_valid_r <= link.out_data;
    end
  end

  // Line faults of the output circuit are not an input here by design
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      held_r <= '0;
    end else if (bus_fault && !watchdog_en) begin
      held_r <= held_r;
    end else if ((bus_fault && watchdog_en) || (link.out_strobe && link.out_invalid)) begin
      case (sub_mode_t'(out_sub_mode))
        SUB_CURRENT: held_r <= link.out_strobe ? link.out_data : held_r;
        SUB_REPLACE: held_r <= out_replace;
        default: held_r <= last_valid_r;
      endcase
    end else if (link.out_strobe) begin
      held_r <= link.out_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_r <= '0;
    end else if (link_lost) begin
      out_r <= '0;
    end else begin
      out_r <= held_r ^ out_inv_mask;
    end
  end

  assign field_out = out_r;
endmodule : rio_module_end

// [include/rio_pkg.sv]
package rio_pkg;
  // Module codes in the configuration string
  localparam logic [7:0] CODE_EMPTY = 8'h00;
  localparam logic [7:0] CODE_DI2 = 8'h10;
  localparam logic [7:0] CODE_DI8 = 8'h11;
  localparam logic [7:0] CODE_DO_DI2 = 8'h30;
  localparam logic [7:0] CODE_DO8 = 8'h31;
  localparam logic [7:0] CODE_AI = 8'h50;
  localparam logic [7:0] PRM_HEADER = 8'h11;
  localparam int NUM_SLOTS = 8;
  localparam logic [3:0] FIRST_SLOT_RED = 4'h3;
  localparam logic [3:0] FIRST_SLOT_STD = 4'h1;
  // Parameter byte field positions
  localparam int PB_LFD = 0;
  localparam int PB_INV = 1;
  localparam int PB_ON = 2;
  localparam int PB_OFF = 4;
  // Telegram bit positions
  localparam int TB_ST1 = 0;
  localparam int TB_LF1 = 1;
  localparam int TB_ST2 = 2;
  localparam int TB_LF2 = 3;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DELAY1_MS = 10;
  localparam int DELAY2_MS = 100;
  localparam int DELAY3_MS = 1000;
  localparam int DELAY1_CYC = DELAY1_MS * CYC_PER_MS;
  localparam int DELAY2_CYC = DELAY2_MS * CYC_PER_MS;
  localparam int DELAY3_CYC = DELAY3_MS * CYC_PER_MS;
  localparam int TELEGRAM_US = 6500;
  localparam int TELEGRAM_CYC = TELEGRAM_US * (CLK_HZ / 1_000_000);
  localparam int LINK_LOSS_MS = 500;
  localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CYC_PER_MS;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  // Substitute value strategies
  typedef enum logic [1:0] {SUB_CURRENT, SUB_REPLACE, SUB_LAST} sub_mode_t;
endpackage : rio_pkg

// [include/rio_if.sv]
`timescale 1ns/1ns
interface rio_if;
  logic [7:0] tel_data;
  logic tel_valid;
  logic tel_ready;
  logic [7:0] out_data;
  logic out_invalid;
  logic out_strobe;
  modport module_end(output tel_data, output tel_valid, input tel_ready,
    input out_data, input out_invalid, input out_strobe);
  modport com_end(input tel_data, input tel_valid, output tel_ready,
    output out_data, output out_invalid, output out_strobe);
endinterface : rio_if

// [hdl/rio_fifo.sv]
`timescale 1ns/1ns
module rio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : rio_fifo

// [hdl/rio_com_end.sv]
`timescale 1ns/1ns
module rio_com_end
  import rio_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link to module
  rio_if.com_end link,
  // User output request
  input wire logic [7:0] user_out_data,
  input wire logic user_out_invalid,
  input wire logic user_out_strobe,
  // User input telegram and drain control
  input wire logic user_in_ready,
  output logic [7:0] user_in_data,
  output logic user_in_valid,
  // Slot configuration string checking
  input wire logic redundant,
  input wire logic [7:0] cfg_code,
  input wire logic [3:0] cfg_slot,
  input wire logic cfg_last,
  input wire logic cfg_strobe,
  output logic cfg_error
);
  import rio_pkg::*;

  logic [7:0] od_r;
  logic oi_r;
  logic os_r;
  logic [7:0] id_r;
  logic iv_r;
  logic expect_empty_r;
  logic err_r;
  logic code_ok;

  assign link.out_data = od_r;
  assign link.out_invalid = oi_r;
  assign link.out_strobe = os_r;
  assign link.tel_ready = !iv_r || user_in_ready;
  assign user_in_data = id_r;
  assign user_in_valid = iv_r;
  assign cfg_error = err_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      od_r <= '0;
      oi_r <= 1'b0;
      os_r <= 1'b0;
    end else begin
      od_r <= user_out_strobe ? user_out_data : od_r;
      oi_r <= user_out_strobe ? user_out_invalid : oi_r;
      os_r <= user_out_strobe;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      id_r <= '0;
      iv_r <= 1'b0;
    end else if (link.tel_valid && link.tel_ready) begin
      id_r <= link.tel_data;
      iv_r <= 1'b1;
    end else if (user_in_ready) begin
      iv_r <= 1'b0;
    end
  end

  always_comb begin
    code_ok = 1'b0;
    if (expect_empty_r) begin
      code_ok = cfg_code == CODE_EMPTY;
    end else if (cfg_code == CODE_DI2 || cfg_code == CODE_DI8 || cfg_code == CODE_DO_DI2
        || cfg_code == CODE_DO8 || cfg_code == CODE_AI) begin
      code_ok = 1'b1;
    end
  end

  // Sticky until reset; a mismatching string only raises cfg_error, cyclic exchange is not blocked
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      err_r <= 1'b0;
      expect_empty_r <= 1'b0;
    end else if (cfg_strobe) begin
      expect_empty_r <= (cfg_code == CODE_DI8 || cfg_code == CODE_DO8) && !cfg_last;
      if (!code_ok || (cfg_last && cfg_code == CODE_EMPTY)) begin
        err_r <= 1'b1;
      end else if (redundant && cfg_slot < FIRST_SLOT_RED) begin
        err_r <= 1'b1;
      end else if (cfg_slot < FIRST_SLOT_STD) begin
        err_r <= 1'b1;
      end
    end
  end
endmodule : rio_com_end

// [verification/rio_properties.sv]
`timescale 1ns/1ns
module rio_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link signals
  input wire logic [7:0] tel_data,
  input wire logic tel_valid,
  input wire logic tel_ready,
  input wire logic [7:0] out_data,
  input wire logic out_invalid,
  input wire logic out_strobe
);
  localparam int FIRST_PUSH = rio_pkg::TELEGRAM_CYC;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int run_cnt;
  // Cycles since reset release, saturating
  always_ff @(posedge sys_clk) begin
    if (rst) run_cnt <= 0;
    else if (run_cnt < 200000) run_cnt <= run_cnt + 1;
  end
  sequence taken_s;
    tel_valid && tel_ready;
  endsequence
  sequence drained_s;
    taken_s ##1 !tel_valid;
  endsequence
  chk_upper_zero: assert property (tel_valid |-> tel_data[7:4] == 4'h0)
    else $error("telegram upper bits set");
  chk_tel_hold: assert property (tel_valid && !tel_ready |=> tel_valid)
    else $error("telegram dropped before taken");
  chk_tel_steady: assert property (tel_valid && !tel_ready |=> $stable(tel_data))
    else $error("telegram changed while waiting");
  chk_strobe_pulse: assert property (out_strobe |=> !out_strobe)
    else $error("output strobe longer than one cycle");
  chk_first_push: assert property ($rose(tel_valid) |-> run_cnt >= FIRST_PUSH)
    else $error("telegram before its period");
  chk_quiet_link: assert property (run_cnt < FIRST_PUSH |-> !tel_valid)
    else $error("link busy before first period");
  chk_push_gap: assert property (drained_s |=> !tel_valid [*8])
    else $error("telegrams too close");
  chk_data_steady: assert property ($fell(out_strobe) |-> $stable(out_data))
    else $error("output data moved after strobe");
endmodule : rio_checker

// [verification/remote_io_channel_data_path_bench.sv]
`timescale 1ns/1ns
module remote_io_channel_data_path_bench;
  import rio_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  logic [7:0] prm_ch1 = 0, prm_ch2 = 0, out_replace = 0, out_inv_mask = 0, user_out_data = 0;
  logic [7:0] cfg_code = 0, field_out, user_in_data, last_ok;
  logic [1:0] field_in = 0, line_fault_in = 0, out_sub_mode = 0;
  logic watchdog_en = 0, bus_fault = 0, user_out_invalid = 0, user_out_strobe = 0;
  logic user_in_ready = 1, user_in_valid, redundant = 0, cfg_last = 0, cfg_strobe = 0, cfg_error;
  logic [3:0] cfg_slot = 0;
  logic [31:0] seed = 32'hD03F5C75;
  int n_errors = 0, checked = 0, k;
  rio_if link_if ();
  rio_module_end rio_module_end_inst (.sys_clk, .rst, .link(link_if), .prm_ch1, .prm_ch2,
    .field_in, .line_fault_in, .out_replace, .out_inv_mask, .out_sub_mode, .watchdog_en,
    .bus_fault, .field_out);
  rio_com_end rio_com_end_inst (.sys_clk, .rst, .link(link_if), .user_out_data,
    .user_out_invalid, .user_out_strobe, .user_in_ready, .user_in_data, .user_in_valid,
    .redundant, .cfg_code, .cfg_slot, .cfg_last, .cfg_strobe, .cfg_error);
  rio_checker rio_checker_inst (.sys_clk, .rst, .tel_data(link_if.tel_data),
    .tel_valid(link_if.tel_valid), .tel_ready(link_if.tel_ready),
    .out_data(link_if.out_data), .out_invalid(link_if.out_invalid),
    .out_strobe(link_if.out_strobe));
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Status byte from sensor levels, faults and channel parameters
  function automatic logic [7:0] exp_tel(input logic [1:0] f, lf, input logic [7:0] p1, p2);
    return {4'h0, lf[1] & p2[0], f[1] ^ p2[1], lf[0] & p1[0], f[0] ^ p1[1]};
  endfunction : exp_tel
  task automatic cmp_byte(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_flag(input logic got, exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag
  task results;
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task do_reset;
    rst = 1;
    repeat (10) @(negedge sys_clk);
    rst = 0;
  endtask : do_reset
  task send(input logic [7:0] v, input logic inv);
    user_out_data = v;
    user_out_invalid = inv;
    user_out_strobe = 1;
    @(negedge sys_clk);
    user_out_strobe = 0;
    repeat (4) @(negedge sys_clk);
  endtask : send
  // Codes packed first entry in the top byte
  task cfg_seq(input logic red, input logic [31:0] c, input logic [3:0] s0, input int n,
    input logic e);
    redundant = red;
    do_reset();
    for (int i = 0; i < n; i++) begin
      cfg_code = c[31-8*i -: 8];
      cfg_slot = s0 + 4'(i);
      cfg_last = (i == n - 1);
      cfg_strobe = 1;
      @(negedge sys_clk);
      cfg_strobe = 0;
      @(negedge sys_clk);
    end
    cmp_flag(cfg_error, e);
  endtask : cfg_seq
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 200000);
    n_errors++;
    results();
  end
  initial begin
    @(negedge sys_clk);
    cfg_seq(0, 32'h10305031, 4'h1, 4, 0);
    cfg_seq(0, 32'h10303100, 4'h1, 4, 1);
    cfg_seq(0, 32'h31001100, 4'h1, 3, 0);
    cfg_seq(0, 32'h10000000, 4'h1, 2, 1);
    cfg_seq(0, 32'h31100000, 4'h1, 2, 1);
    cfg_seq(0, 32'h20000000, 4'h1, 1, 1);
    cfg_seq(1, 32'h10500000, 4'h1, 2, 1);
    cfg_seq(1, 32'h10500000, 4'h3, 2, 0);
    redundant = 0;
    do_reset();
    watchdog_en = 1;
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      out_inv_mask = (i == 0) ? 8'hFF : seed[15:8];
      send(seed[7:0], 0);
      cmp_byte(field_out, seed[7:0] ^ out_inv_mask);
    end
    out_inv_mask = 0;
    last_ok = seed[23:16];
    send(last_ok, 0);
    out_replace = seed[31:24];
    for (int m = 0; m < 3; m++) begin
      seed = lfsr(seed);
      out_sub_mode = m[1:0];
      send(seed[7:0], 1);
      cmp_byte(field_out, m == 0 ? seed[7:0] : m == 1 ? out_replace : last_ok);
    end
    out_sub_mode = 1;
    bus_fault = 1;
    repeat (4) @(negedge sys_clk);
    cmp_byte(field_out, out_replace);
    watchdog_en = 0;
    out_sub_mode = 0;
    send(~last_ok, 0);
    cmp_byte(field_out, out_replace);
    bus_fault = 0;
    prm_ch1 = 8'h01;
    prm_ch2 = 8'h02;
    field_in = seed[9:8];
    line_fault_in = 2'b11;
    user_in_ready = 0;
    k = 0;
    while (link_if.tel_valid !== 1'b1 && k < 140000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (20) @(negedge sys_clk);
    user_in_ready = 1;
    while (user_in_valid !== 1'b1 && k < 140100) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 140000) n_errors++;
    cmp_flag(user_in_valid, 1'b1);
    cmp_byte(user_in_data, exp_tel(field_in, line_fault_in, prm_ch1, prm_ch2));
    @(negedge sys_clk);
    cmp_flag(user_in_valid, 1'b0);
    results();
  end
endmodule : remote_io_channel_data_path_bench
